// ### rtl/ptf_params.svh
`ifndef PTF_PARAMS_SVH
`define PTF_PARAMS_SVH

// -----------------------------------------------------------------
// clock and timebase
// -----------------------------------------------------------------
`define PTF_CLK_MHZ        125
`define PTF_TB0_US         1
`define PTF_TB1_US         100
`define PTF_TB2_US         10000
`define PTF_TB3_US         1000000

// -----------------------------------------------------------------
// register byte addresses
// -----------------------------------------------------------------
`define PTF_ADDR_CTRL      8'h00
`define PTF_ADDR_HIGH      8'h04
`define PTF_ADDR_LOW       8'h08
`define PTF_ADDR_SRC       8'h0C
`define PTF_ADDR_STATUS    8'h10

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define PTF_CTRL_MODE_LSB  0
`define PTF_CTRL_RET_BIT   2
`define PTF_CTRL_TB_LSB    4
`define PTF_CTRL_N_LSB     8
`define PTF_SRC_LOW_LSB    8
`define PTF_STAT_ST_LSB    1
`define PTF_STAT_CYC_LSB   4
`define PTF_STAT_EL_LSB    16

// -----------------------------------------------------------------
// reset values and limits
// -----------------------------------------------------------------
`define PTF_CTRL_RST       12'h100
`define PTF_HIGH_RST       16'h000A
`define PTF_LOW_RST        16'h000A
`define PTF_SRC_RST        16'h0000
`define PTF_N_MIN          4'h1
`define PTF_N_MAX          4'h9

`endif

// ### rtl/ptf_pkg.sv
package ptf_pkg;
   typedef enum logic [1:0] {PTF_WIPE, PTF_EDGE, PTF_ASYNC, PTF_OFF} ptf_mode_t;
   typedef enum logic [1:0] {PTF_IDLE, PTF_LOW, PTF_HIGH} ptf_state_t;
endpackage

// ### rtl/ptf_ev_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ptf_ev_if #(parameter int W = 5);
   logic [W-1:0] lvl;
   logic [W-1:0] rise;
   logic [W-1:0] fall;
   logic         tick;
   modport sync (output lvl, output rise, output fall);
   modport pre  (output tick);
   modport core (input lvl, input rise, input fall, input tick);
endinterface
`default_nettype wire

// ### rtl/ptf_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ptf_sync
   import ptf_pkg::*;
#(
   parameter int W = 5
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] in_raw,
   ptf_ev_if.sync            ev
);
   // -----------------------------------------------------------------
   // two-stage synchroniser and edge detect
   // -----------------------------------------------------------------
   logic [W-1:0] meta_reg;
   logic [W-1:0] stable_reg;
   logic [W-1:0] prev_reg;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         meta_reg   <= '0;
         stable_reg <= '0;
         prev_reg   <= '0;
      end else begin
         meta_reg   <= in_raw;
         stable_reg <= meta_reg;
         prev_reg   <= stable_reg;
      end
   end

   assign ev.lvl  = stable_reg;
   assign ev.rise = stable_reg & ~prev_reg;
   assign ev.fall = ~stable_reg & prev_reg;
endmodule
`default_nettype wire

// ### rtl/ptf_tick.sv
`timescale 1ns/10ps
`default_nettype none
module ptf_tick
   import ptf_pkg::*;
#(
   parameter logic [31:0] C0 = 32'd1,
   parameter logic [31:0] C1 = 32'd1,
   parameter logic [31:0] C2 = 32'd1,
   parameter logic [31:0] C3 = 32'd1
) (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic [1:0] sel,
   ptf_ev_if.pre           ev
);
   // -----------------------------------------------------------------
   // timebase prescaler
   // -----------------------------------------------------------------
   logic [31:0] cnt_reg;
   logic [31:0] limit;
   logic        wrap;

   assign limit = (sel == 2'd0) ? C0 : (sel == 2'd1) ? C1 : (sel == 2'd2) ? C2 : C3;
   assign wrap  = (cnt_reg + 32'd1 >= limit);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cnt_reg <= '0;
      end else if (wrap) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + 32'd1;
      end
   end

   assign ev.tick = wrap;
endmodule
`default_nettype wire

// ### rtl/ptf_top.sv
// Behaviour
// - pulse mode: launch rise sets output high, elapsed restarts at zero
// - pulse mode: output drops when elapsed equals high span
// - pulse mode: launch fall before span ends drops output at once
// - pulse mode: output high only while launch input stays high
// - after power loss retentive keeps output and elapsed, else defaults
// - retentive setting per block: off or retained
// - edge mode: rise starts low span, then output high for high span
// - edge mode: a new rise inside the cycle restarts it from zero
// - edge mode: halt clears elapsed and drives output low
// - edge mode: each trigger gives N low/high cycles, N from 1 to 9
// - generator mode: enable input switches generator on and off
// - generator mode: high span then low span, repeating while enabled
// - generator mode: flip input inverts output only while enabled
// - a span may come from another block's value, chosen by number
// - timebase configurable; all span counts step in timebase units
`timescale 1ns/10ps
`default_nettype none
`include "ptf_params.svh"
module ptf_top
   import ptf_pkg::*;
#(
   parameter int          SPAN_W = 16,
   parameter int          NSRC   = 4,
   parameter logic [31:0] TB0_CYC = 32'(`PTF_TB0_US * `PTF_CLK_MHZ),
   parameter logic [31:0] TB1_CYC = 32'(`PTF_TB1_US * `PTF_CLK_MHZ),
   parameter logic [31:0] TB2_CYC = 32'(`PTF_TB2_US * `PTF_CLK_MHZ),
   parameter logic [31:0] TB3_CYC = 32'(`PTF_TB3_US * `PTF_CLK_MHZ)
) (
   input  wire logic                     clock,
   input  wire logic                     rst_n,
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic                          hreadyout,
   output logic                          hresp,
   output logic [31:0]                   hrdata,
   input  wire logic                     launch_in,
   input  wire logic                     halt_in,
   input  wire logic                     enable_in,
   input  wire logic                     flip_in,
   input  wire logic                     power_lost_in,
   input  wire logic [NSRC*SPAN_W-1:0]   src_vals,
   output logic                          pulse_out,
   output logic [SPAN_W-1:0]             elapsed_span
);
   // -----------------------------------------------------------------
   // functions
   // -----------------------------------------------------------------
   function automatic logic [SPAN_W-1:0] pick_span(input logic [SPAN_W-1:0]      own,
                                                   input logic [7:0]             num,
                                                   input logic [NSRC*SPAN_W-1:0] vals);
      logic [SPAN_W-1:0] r;
      r = own;
      for (int i = 0; i < NSRC; i++) begin
         if (num == 8'(i + 1)) begin
            r = vals[i*SPAN_W +: SPAN_W];
         end
      end
      return r;
   endfunction

   function automatic logic [3:0] clamp_n(input logic [3:0] n);
      return (n < `PTF_N_MIN) ? `PTF_N_MIN : (n > `PTF_N_MAX) ? `PTF_N_MAX : n;
   endfunction

   // -----------------------------------------------------------------
   // input sampling and timebase
   // -----------------------------------------------------------------
   ptf_ev_if #(.W(5)) ev ();

   logic [11:0] ctrl_reg;
   logic [1:0]  tb_sel;

   ptf_sync #(.W(5)) u_sync (
      .clock  (clock),
      .rst_n  (rst_n),
      .in_raw ({power_lost_in, flip_in, enable_in, halt_in, launch_in}),
      .ev     (ev.sync)
   );

   ptf_tick #(.C0(TB0_CYC), .C1(TB1_CYC), .C2(TB2_CYC), .C3(TB3_CYC)) u_tick (
      .clock (clock),
      .rst_n (rst_n),
      .sel   (tb_sel),
      .ev    (ev.pre)
   );

   wire launch_rise = ev.rise[0];
   wire launch_fall = ev.fall[0];
   wire launch_lvl  = ev.lvl[0];
   wire halt_lvl    = ev.lvl[1];
   wire en_lvl      = ev.lvl[2];
   wire flip_lvl    = ev.lvl[3];
   wire lost_lvl    = ev.lvl[4];
   wire restore     = ev.fall[4];

   // -----------------------------------------------------------------
   // ahb-lite slave
   // -----------------------------------------------------------------
   logic [SPAN_W-1:0] high_span_reg;
   logic [SPAN_W-1:0] low_span_reg;
   logic [15:0]       src_reg;
   logic              dp_wr_reg;
   logic [7:0]        dp_addr_reg;
   logic [31:0]       hrdata_reg;
   logic [31:0]       rd_mux;
   logic [31:0]       status_word;
   ptf_state_t        st_reg;
   ptf_state_t        st_next;
   logic [SPAN_W-1:0] elapsed_reg;
   logic [SPAN_W-1:0] elapsed_next;
   logic              q_reg;
   logic              q_next;
   logic [3:0]        cyc_reg;
   logic [3:0]        cyc_next;
   logic              out_reg;
   logic              out_next;

   wire       ap_valid = hsel & htrans[1] & hready;
   wire [7:0] ap_addr  = haddr[7:0];
   wire       ctrl_wr  = dp_wr_reg && (dp_addr_reg == `PTF_ADDR_CTRL);

   assign status_word = {SPAN_W'(elapsed_reg), 8'h00, cyc_reg, 1'b0, 2'(st_reg), q_reg};
   assign rd_mux = (ap_addr == `PTF_ADDR_CTRL)   ? {20'h0_0000, ctrl_reg} :
                   (ap_addr == `PTF_ADDR_HIGH)   ? 32'(high_span_reg) :
                   (ap_addr == `PTF_ADDR_LOW)    ? 32'(low_span_reg) :
                   (ap_addr == `PTF_ADDR_SRC)    ? {16'h0000, src_reg} :
                   (ap_addr == `PTF_ADDR_STATUS) ? status_word : 32'h0000_0000;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dp_wr_reg   <= 1'b0;
         dp_addr_reg <= 8'h00;
         hrdata_reg  <= 32'h0000_0000;
      end else begin
         dp_wr_reg   <= ap_valid & hwrite;
         dp_addr_reg <= ap_addr;
         if (ap_valid && !hwrite) begin
            hrdata_reg <= rd_mux;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_reg      <= `PTF_CTRL_RST;
         high_span_reg <= `PTF_HIGH_RST;
         low_span_reg  <= `PTF_LOW_RST;
         src_reg       <= `PTF_SRC_RST;
      end else if (dp_wr_reg) begin
         if (dp_addr_reg == `PTF_ADDR_CTRL) ctrl_reg <= hwdata[11:0];
         if (dp_addr_reg == `PTF_ADDR_HIGH) high_span_reg <= hwdata[SPAN_W-1:0];
         if (dp_addr_reg == `PTF_ADDR_LOW) low_span_reg <= hwdata[SPAN_W-1:0];
         if (dp_addr_reg == `PTF_ADDR_SRC) src_reg <= hwdata[15:0];
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;

   // -----------------------------------------------------------------
   // configuration decode
   // -----------------------------------------------------------------
   ptf_mode_t         mode;
   logic              retentive;
   logic [3:0]        n_eff;
   logic [SPAN_W-1:0] span_h;
   logic [SPAN_W-1:0] span_l;
   logic [SPAN_W-1:0] el_inc;
   logic              hit_h;
   logic              hit_l;

   assign mode      = ptf_mode_t'(ctrl_reg[`PTF_CTRL_MODE_LSB +: 2]);
   assign retentive = ctrl_reg[`PTF_CTRL_RET_BIT];
   assign tb_sel    = ctrl_reg[`PTF_CTRL_TB_LSB +: 2];
   assign n_eff     = clamp_n(ctrl_reg[`PTF_CTRL_N_LSB +: 4]);
   assign span_h    = pick_span(high_span_reg, src_reg[7:0], src_vals);
   assign span_l    = pick_span(low_span_reg, src_reg[`PTF_SRC_LOW_LSB +: 8], src_vals);
   assign el_inc    = ev.tick ? elapsed_reg + SPAN_W'(1) : elapsed_reg;
   assign hit_h     = (elapsed_reg == span_h);
   assign hit_l     = (elapsed_reg == span_l);

   // -----------------------------------------------------------------
   // timing engine
   // -----------------------------------------------------------------
   always_comb begin
      st_next      = st_reg;
      elapsed_next = elapsed_reg;
      q_next       = q_reg;
      cyc_next     = cyc_reg;
      if (lost_lvl) begin
         st_next = st_reg;
      end else if ((restore && !retentive) || ctrl_wr) begin
         st_next      = PTF_IDLE;
         elapsed_next = '0;
         q_next       = 1'b0;
         cyc_next     = 4'h0;
      end else begin
         unique case (mode)
            PTF_WIPE: begin
               if (launch_rise) begin
                  st_next      = PTF_HIGH;
                  elapsed_next = '0;
                  q_next       = 1'b1;
               end else if (st_reg == PTF_HIGH) begin
                  if (launch_fall || !launch_lvl || hit_h) begin
                     st_next = PTF_IDLE;
                     q_next  = 1'b0;
                  end else begin
                     elapsed_next = el_inc;
                  end
               end
            end
            PTF_EDGE: begin
               if (halt_lvl) begin
                  st_next      = PTF_IDLE;
                  elapsed_next = '0;
                  q_next       = 1'b0;
                  cyc_next     = 4'h0;
               end else if (launch_rise) begin
                  st_next      = PTF_LOW;
                  elapsed_next = '0;
                  q_next       = 1'b0;
                  cyc_next     = n_eff;
               end else if (st_reg == PTF_LOW) begin
                  if (hit_l) begin
                     st_next      = PTF_HIGH;
                     elapsed_next = '0;
                     q_next       = 1'b1;
                  end else begin
                     elapsed_next = el_inc;
                  end
               end else if (st_reg == PTF_HIGH) begin
                  if (hit_h) begin
                     st_next      = (cyc_reg > 4'h1) ? PTF_LOW : PTF_IDLE;
                     elapsed_next = '0;
                     q_next       = 1'b0;
                     cyc_next     = cyc_reg - 4'h1;
                  end else begin
                     elapsed_next = el_inc;
                  end
               end
            end
            PTF_ASYNC: begin
               if (!en_lvl) begin
                  st_next      = PTF_IDLE;
                  elapsed_next = '0;
                  q_next       = 1'b0;
               end else if (st_reg == PTF_IDLE || (st_reg == PTF_LOW && hit_l)) begin
                  st_next      = PTF_HIGH;
                  elapsed_next = '0;
                  q_next       = 1'b1;
               end else if (st_reg == PTF_HIGH && hit_h) begin
                  st_next      = PTF_LOW;
                  elapsed_next = '0;
                  q_next       = 1'b0;
               end else begin
                  elapsed_next = el_inc;
               end
            end
            default: begin
               st_next      = PTF_IDLE;
               elapsed_next = '0;
               q_next       = 1'b0;
            end
         endcase
      end
   end

   assign out_next = lost_lvl ? 1'b0 :
                     (mode != PTF_ASYNC) ? q_next :
                     (en_lvl ? (q_next ^ flip_lvl) : 1'b0);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_reg      <= PTF_IDLE;
         elapsed_reg <= '0;
         q_reg       <= 1'b0;
         cyc_reg     <= 4'h0;
         out_reg     <= 1'b0;
      end else begin
         st_reg      <= st_next;
         elapsed_reg <= elapsed_next;
         q_reg       <= q_next;
         cyc_reg     <= cyc_next;
         out_reg     <= out_next;
      end
   end

   assign pulse_out    = out_reg;
   assign elapsed_span = elapsed_reg;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   wire act = !lost_lvl && !ctrl_wr && !restore;

   sequence low_done_s;
      act && mode == PTF_EDGE && st_reg == PTF_LOW && hit_l && !halt_lvl && !launch_rise;
   endsequence

   sequence high_last_s;
      act && mode == PTF_EDGE && st_reg == PTF_HIGH && hit_h && cyc_reg == 4'h1
         && !halt_lvl && !launch_rise;
   endsequence

   wipe_start_a: assert property (act && mode == PTF_WIPE && launch_rise
      |=> pulse_out && elapsed_span == '0) else $error("pulse start wrong");
   wipe_end_a: assert property (act && mode == PTF_WIPE && st_reg == PTF_HIGH && hit_h
      && !launch_rise |=> !pulse_out) else $error("pulse did not end");
   wipe_fall_a: assert property (act && mode == PTF_WIPE && launch_fall
      |=> !pulse_out) else $error("fall did not end pulse");
   wipe_hold_a: assert property (pulse_out && $past(mode == PTF_WIPE) && $past(act)
      |-> $past(launch_lvl)) else $error("pulse without launch");
   restore_clr_a: assert property (restore && !retentive && !ctrl_wr
      |=> elapsed_span == '0 && !pulse_out) else $error("state kept");
   edge_span_a: assert property (low_done_s |=> st_reg == PTF_HIGH && pulse_out
      && elapsed_span == '0) else $error("low span end wrong");
   edge_retrig_a: assert property (act && mode == PTF_EDGE && launch_rise && !halt_lvl
      |=> st_reg == PTF_LOW && elapsed_span == '0) else $error("no restart");
   edge_halt_a: assert property (act && mode == PTF_EDGE && halt_lvl
      |=> !pulse_out && elapsed_span == '0) else $error("halt ignored");
   edge_count_a: assert property (high_last_s |=> st_reg == PTF_IDLE && !pulse_out)
      else $error("cycle count wrong");
   gen_off_a: assert property (act && mode == PTF_ASYNC && !en_lvl
      |=> !pulse_out) else $error("disabled output high");
   gen_flip_a: assert property (act && mode == PTF_ASYNC && en_lvl && st_reg == PTF_HIGH
      && !hit_h |=> pulse_out == !$past(flip_lvl)) else $error("flip wrong");
endmodule
`default_nettype wire

// ### sim/ptf_src_model.sv
`timescale 1ns/10ps
`default_nettype none
// -----------------------------------------------------------------
// other function blocks: actual values chosen by block number
// -----------------------------------------------------------------
module ptf_src_model #(
   parameter int SPAN_W = 16,
   parameter int NSRC   = 4
) (
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic                   load,
   input  wire logic [7:0]             slot,
   input  wire logic [SPAN_W-1:0]      value,
   output logic      [NSRC*SPAN_W-1:0] src_vals
);
   logic [SPAN_W-1:0] val_reg [NSRC];
   always_ff @(posedge clock) begin
      for (int k = 0; k < NSRC; k++) begin
         if (!rst_n) begin
            val_reg[k] <= SPAN_W'(k + 1);
         end else if (load && slot == 8'(k + 1)) begin
            val_reg[k] <= value;
         end
      end
   end
   always_comb begin
      for (int k = 0; k < NSRC; k++) begin
         src_vals[k*SPAN_W +: SPAN_W] = val_reg[k];
      end
   end
endmodule
`default_nettype wire

// ### sim/pulse_timer_functions_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ptf_params.svh"
module pulse_timer_functions_tb_top import ptf_pkg::*;;
   typedef struct {logic [31:0] a; logic [31:0] wd; logic [31:0] e;} ptf_row_t;
   logic        clock;
   logic        rst_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic        hready;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        launch_in;
   logic        halt_in;
   logic        enable_in;
   logic        flip_in;
   logic        power_lost_in;
   logic [63:0] src_vals;
   logic        pulse_out;
   logic [15:0] elapsed_span;
   logic        ld;
   logic [7:0]  slot;
   logic [15:0] val;
   logic        pp;
   int          miscompares;
   int          samples_checked;
   int          n;
   int          e1;
   ptf_row_t    rows [5] = '{
      '{32'(`PTF_ADDR_HIGH), 32'h0000_1234, 32'h0000_1234},
      '{32'(`PTF_ADDR_LOW),  32'hFFFF_0021, 32'h0000_0021},
      '{32'(`PTF_ADDR_SRC),  32'h0000_0201, 32'h0000_0201},
      '{32'(`PTF_ADDR_CTRL), 32'h0000_0935, 32'h0000_0935},
      '{32'h0000_0020,       32'hFFFF_FFFF, 32'h0000_0000}};
   // -----------------------------------------------------------------
   // clock, design and far side
   // -----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   assign hready = hreadyout;
   ptf_top #(.TB0_CYC(32'd1), .TB1_CYC(32'd2), .TB2_CYC(32'd3), .TB3_CYC(32'd4)) dut (
      .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .launch_in(launch_in),
      .halt_in(halt_in), .enable_in(enable_in), .flip_in(flip_in),
      .power_lost_in(power_lost_in), .src_vals(src_vals), .pulse_out(pulse_out),
      .elapsed_span(elapsed_span));
   ptf_src_model partner (.clock(clock), .rst_n(rst_n), .load(ld), .slot(slot),
      .value(val), .src_vals(src_vals));
   // -----------------------------------------------------------------
   // tasks
   // -----------------------------------------------------------------
   task automatic test_done();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clock);
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      int k;
      k = 0;
      hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w;
      do begin @(posedge clock); k++; end while (hready !== 1'b1 && k < 100);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
      do begin @(posedge clock); k++; end while (hready !== 1'b1 && k < 100);
      r = hrdata;
      chk("hresp", 32'h0000_0000, 32'(hresp));
      if (k >= 100) begin miscompares++; test_done(); end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0000_0000, r);
      chk(nm, e, r);
   endtask
   task automatic cfg(input logic [31:0] c, input logic [15:0] hi, input logic [15:0] lo,
                      input logic [15:0] s);
      wr(32'(`PTF_ADDR_SRC), 32'(s));
      wr(32'(`PTF_ADDR_HIGH), 32'(hi));
      wr(32'(`PTF_ADDR_LOW), 32'(lo));
      wr(32'(`PTF_ADDR_CTRL), c);
   endtask
   task automatic wait_until(input logic lvl, output int c);
      c = 0;
      while (pulse_out !== lvl) begin
         @(posedge clock);
         c++;
         if (c > 3000) begin miscompares++; test_done(); end
      end
   endtask
   task automatic fire();
      launch_in <= 1'b1;
      @(posedge clock);
      launch_in <= 1'b0;
   endtask
   task automatic do_reset();
      rst_n <= 1'b0;
      cyc(12);
      rst_n <= 1'b1;
      @(posedge clock);
   endtask
   task automatic last_high(output int e);
      int k;
      k = 0;
      e = 0;
      while (pulse_out === 1'b1 && k < 3000) begin
         e = elapsed_span;
         @(posedge clock);
         k++;
      end
      if (k >= 3000) begin miscompares++; test_done(); end
   endtask
   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      rst_n = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0; hwdata = '0;
      launch_in = 1'b0; halt_in = 1'b0; enable_in = 1'b0; flip_in = 1'b0;
      power_lost_in = 1'b0; ld = 1'b0; slot = '0; val = '0;
      miscompares = 0; samples_checked = 0;
      do_reset();
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].wd);
         rdc("register", rows[i].a, rows[i].e);
      end
      cfg(32'h0000_0100, 16'd5, 16'd10, 16'd0);
      launch_in <= 1'b1;
      wait_until(1'b1, n);
      chk("start elapsed", 32'h0000_0000, 32'(elapsed_span));
      last_high(e1);
      chk("end elapsed", 32'd5, 32'(e1));
      launch_in <= 1'b0;
      cfg(32'h0000_0100, 16'd200, 16'd10, 16'd0);
      launch_in <= 1'b1;
      wait_until(1'b1, n);
      cyc(5);
      chk("held", 32'd1, 32'(pulse_out));
      launch_in <= 1'b0;
      cyc(4);
      chk("early end", 32'd0, 32'(pulse_out));
      cfg(32'h0000_0130, 16'd5, 16'd10, 16'd0);
      launch_in <= 1'b1;
      wait_until(1'b1, n);
      wait_until(1'b0, n);
      chk("timebase", 32'd1, 32'(n >= 16 && n <= 22));
      launch_in <= 1'b0;
      ld <= 1'b1; slot <= 8'd2; val <= 16'd7;
      cfg(32'h0000_0100, 16'd50, 16'd10, 16'h0002);
      ld <= 1'b0;
      launch_in <= 1'b1;
      wait_until(1'b1, n);
      last_high(e1);
      chk("source span", 32'd7, 32'(e1));
      launch_in <= 1'b0;
      foreach (rows[i]) begin
         if (i < 3) begin
            e1 = (i == 0) ? 1 : (i == 1) ? 2 : 9;
            cfg(32'h0000_0001 | 32'(e1 << 8), 16'd3, 16'd4, 16'd0);
            fire();
            wait_until(1'b1, n);
            chk("low first", 32'd1, 32'(n >= 4));
            n = 1;
            pp = pulse_out;
            for (int k = 0; k < 200; k++) begin
               @(posedge clock);
               n += int'(pulse_out === 1'b1 && pp === 1'b0);
               pp = pulse_out;
            end
            chk("cycles", 32'(e1), 32'(n));
         end
      end
      cfg(32'h0000_0101, 16'd20, 16'd20, 16'd0);
      fire();
      wait_until(1'b1, n);
      chk("high elapsed", 32'd0, 32'(elapsed_span));
      cyc(5);
      chk("progress", 32'd5, 32'(elapsed_span));
      fire();
      cyc(3);
      chk("retrigger", 32'd0, 32'(pulse_out));
      wait_until(1'b1, n);
      chk("restart low", 32'd1, 32'(n >= 19));
      halt_in <= 1'b1;
      cyc(4);
      chk("halt out", 32'd0, 32'(pulse_out));
      chk("halt elapsed", 32'd0, 32'(elapsed_span));
      rdc("status", 32'(`PTF_ADDR_STATUS), 32'h0000_0000);
      halt_in <= 1'b0;
      cfg(32'h0000_0102, 16'd3, 16'd5, 16'd0);
      flip_in <= 1'b1;
      cyc(6);
      chk("off flip", 32'd0, 32'(pulse_out));
      flip_in <= 1'b0;
      enable_in <= 1'b1;
      wait_until(1'b1, n);
      chk("on", 32'd1, 32'(n <= 6));
      wait_until(1'b0, n);
      chk("high run", 32'd4, 32'(n));
      wait_until(1'b1, n);
      chk("low run", 32'd6, 32'(n));
      enable_in <= 1'b0;
      cfg(32'h0000_0102, 16'd200, 16'd200, 16'd0);
      enable_in <= 1'b1;
      wait_until(1'b1, n);
      cyc(4);
      flip_in <= 1'b1;
      cyc(4);
      chk("flip", 32'd0, 32'(pulse_out));
      enable_in <= 1'b0;
      cyc(4);
      chk("off", 32'd0, 32'(pulse_out));
      flip_in <= 1'b0;
      for (int r = 0; r < 2; r++) begin
         cfg(32'h0000_0100 | 32'(r << 2), 16'd200, 16'd10, 16'd0);
         launch_in <= 1'b1;
         wait_until(1'b1, n);
         cyc(10);
         power_lost_in <= 1'b1;
         cyc(4);
         chk("lost out", 32'd0, 32'(pulse_out));
         e1 = elapsed_span;
         cyc(10);
         chk("frozen", 32'(e1), 32'(elapsed_span));
         power_lost_in <= 1'b0;
         cyc(4);
         chk("restore out", 32'(r), 32'(pulse_out));
         chk("restore time", 32'd1, 32'(r ? elapsed_span >= e1 : elapsed_span == 0));
         launch_in <= 1'b0;
      end
      cfg(32'h0000_0103, 16'd3, 16'd5, 16'd0);
      launch_in <= 1'b1;
      cyc(6);
      chk("off mode", 32'd0, 32'(pulse_out));
      launch_in <= 1'b0;
      enable_in <= 1'b1;
      cfg(32'h0000_0102, 16'd3, 16'd5, 16'd0);
      cyc(20);
      do_reset();
      chk("reset out", 32'd0, 32'(pulse_out));
      chk("reset elapsed", 32'd0, 32'(elapsed_span));
      rdc("ctrl", 32'(`PTF_ADDR_CTRL), 32'(`PTF_CTRL_RST));
      rdc("high", 32'(`PTF_ADDR_HIGH), 32'(`PTF_HIGH_RST));
      rdc("low", 32'(`PTF_ADDR_LOW), 32'(`PTF_LOW_RST));
      rdc("src", 32'(`PTF_ADDR_SRC), 32'(`PTF_SRC_RST));
      test_done();
   end
endmodule
`default_nettype wire
